// ---- pfss_top.sv ----
// Fault response, power-good, sync setup and soft start/stop sequencing.
// Assumes command writes arrive on clk_i; fault and remote-on pins are async.
//
// Overview of operation
// (RULE1) Guard limit equals setpoint minus held offset, recomputed on new setpoint
// (RULE2) Guard offset resets to 0.192 V below setpoint
// (RULE3) Latch-off: fault stops output until clear command or re-enable; code restarts without clear after an undervoltage in ramp-up
// (RULE4) Hiccup: fault stops output, restarts after interval while fault persists
// (RULE5) All three responses reset to latch-off, each with own command
// (RULE6) Power-good low when stopped, high only while regulating
// (RULE7) Current faults ignored during ramp-up, checked after it
// (RULE8) No delayed shutdown; only latch-off or hiccup selectable
// (RULE9) Reverse-current fault uses same response options as over-current
// (RULE10) Effective switching rate is twice per-phase frequency
// (RULE11) Default frequency 500 kHz; 800 kHz suggested for high outputs
// (RULE12) Default clocking internal, sync pin ignored
// (RULE13) Host makes at most one module drive the shared sync line
// (RULE14) Pin function assigned before sync setup is written
// (RULE15) Sync setup holds out enable, input divider, phase offsets
// (RULE16) Sync setup holds pwm dividers, lock gains, lock enables
// (RULE17) Sync setup selects output channel and per-channel clock source
// (RULE18) Sync setup writes refused while regulating
// (RULE19) Phases 180 degrees apart; host steps modules by 360/2n
// (RULE20) On-delay before ramp up, off-delay before ramp down
// (RULE21) Soft-stop off by default; when on, ramp down over fall time
// (RULE22) Four programmable times: on-delay, rise, off-delay, fall
// (RULE23) Time sequencing: common enable to all modules
// (RULE24) Event sequencing: power-good chains to next remote-on
// (RULE25) Remote-on polarity configurable; active-high enables on high
// (RULE26) Hiccup interval counter reload is a build parameter
`timescale 1ns/1ps
module pfss_top #(
  parameter int HICCUP_CYCLES = pfss_pkg::PFSS_HICCUP_CYCLES,
  parameter int MS_CYCLES     = pfss_pkg::PFSS_MS_CYCLES
) (
  input  wire logic                   clk_i,
  input  wire logic                   rst_n_i,
  input  wire logic                   link_clk_i,
  input  pfss_pkg::pfss_cmd_type      cmd_i,
  input  wire logic [7:0]             rd_addr_i,
  output logic [pfss_pkg::PFSS_DATA_W-1:0] rd_data_o,
  input  wire logic                   remote_on_i,
  input  pfss_pkg::pfss_fault_type    fault_i,
  output logic                        supply_ok_out_o,
  output logic                        regulate_o,
  output logic [15:0]                 uv_limit_o,
  output logic [16:0]                 eff_freq_o,
  output logic                        use_ext_clk_o,
  output logic                        sync_drive_o,
  output logic                        sync_oe_o,
  output logic [1:0]                  ramp_dir_o
);
  import pfss_pkg::*;

  localparam int CW = 32;

  pfss_state_type state_r;
  logic [PFSS_PIN_W-1:0]  pin_assign_r;
  logic [PFSS_SYNC_W-1:0] sync_setup_r;
  logic [15:0] vout_r, uv_off_r, freq_r;
  logic [15:0] ton_delay_r, ton_rise_r, toff_delay_r, toff_fall_r;
  logic [1:0]  uv_resp_r, oc_resp_r, uc_resp_r;
  logic        soft_stop_r, pol_high_r, op_on_r;
  logic [CW-1:0] tmr_r;
  logic [15:0] ms_left_r;
  logic        latched_r;
  logic [2:0]  fault_seen_r;
  logic [1:0]  on_sync_r;
  logic [2:0]  flt_s1_r, flt_s2_r;
  logic [2:0]  tick_sync_r;
  logic        link_tick;
  logic        enable;
  logic        cur_fault, any_fault;
  logic        wr_ok;

  function automatic logic [CW-1:0] ms_to_cyc(input logic [15:0] ms);
    ms_to_cyc = CW'(ms) * CW'(MS_CYCLES);
  endfunction : ms_to_cyc

  function automatic logic [1:0] resp_of(input logic [PFSS_DATA_W-1:0] d);
    // Only immediate latch-off or hiccup exist
    resp_of = d[0] ? PFSS_RESP_HICCUP : PFSS_RESP_LATCH; // RULE8
  endfunction : resp_of

  // Two-flop synchronisers for pins
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      on_sync_r <= 2'h0;
      flt_s1_r  <= 3'h0;
      flt_s2_r  <= 3'h0;
    end else begin
      on_sync_r <= {on_sync_r[0], remote_on_i};
      flt_s1_r  <= {fault_i.uv, fault_i.oc, fault_i.uc};
      flt_s2_r  <= flt_s1_r;
    end
  end

  // Remote-on polarity and command enable
  assign enable = op_on_r & (pol_high_r ? on_sync_r[1] : ~on_sync_r[1]); // RULE25
  // Current faults only count once ramp-up is done
  assign cur_fault = (state_r == PFSS_REG) && (flt_s2_r[1] | flt_s2_r[0]); // RULE7
  assign any_fault = cur_fault | ((state_r == PFSS_REG) && flt_s2_r[2]);
  // Sync setup locked while regulating
  assign wr_ok = (state_r == PFSS_IDLE) || (state_r == PFSS_FAULT); // RULE18

  // Configuration registers
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_assign_r <= '0;
      sync_setup_r <= '0; // RULE12
      vout_r       <= PFSS_VOUT_RST;
      uv_off_r     <= PFSS_UV_OFFSET_RST; // RULE2
      freq_r       <= PFSS_FREQ_RST; // RULE11
      ton_delay_r  <= PFSS_TIME_RST;
      ton_rise_r   <= PFSS_TIME_RST;
      toff_delay_r <= PFSS_TIME_RST;
      toff_fall_r  <= PFSS_TIME_RST;
      uv_resp_r    <= PFSS_RESP_LATCH; // RULE5
      oc_resp_r    <= PFSS_RESP_LATCH;
      uc_resp_r    <= PFSS_RESP_LATCH;
      soft_stop_r  <= 1'b0; // RULE21
      pol_high_r   <= 1'b1;
      op_on_r      <= 1'b1;
    end else if (cmd_i.wr) begin
      case (cmd_i.addr)
        PFSS_OFF_PIN_ASSIGN: pin_assign_r <= cmd_i.data[PFSS_PIN_W-1:0];
        PFSS_OFF_SYNC_SETUP: if (wr_ok) sync_setup_r <= cmd_i.data[PFSS_SYNC_W-1:0]; // RULE18
        PFSS_OFF_CMD_VOUT:   vout_r <= cmd_i.data[15:0]; // RULE1
        // Limit written as absolute, stored as offset
        PFSS_OFF_UV_LIMIT:   uv_off_r <= vout_r - cmd_i.data[15:0]; // RULE1
        PFSS_OFF_UV_RESP:    uv_resp_r <= resp_of(cmd_i.data); // RULE5
        PFSS_OFF_OC_RESP:    oc_resp_r <= resp_of(cmd_i.data);
        PFSS_OFF_UC_RESP:    uc_resp_r <= resp_of(cmd_i.data); // RULE9
        PFSS_OFF_ONOFF_CFG: begin
          soft_stop_r <= cmd_i.data[0]; // RULE21
          pol_high_r  <= cmd_i.data[1]; // RULE25
        end
        PFSS_OFF_OPERATION:  op_on_r <= cmd_i.data[7];
        PFSS_OFF_FREQ:       freq_r <= cmd_i.data[15:0];
        PFSS_OFF_TON_DELAY:  ton_delay_r <= cmd_i.data[15:0]; // RULE22
        PFSS_OFF_TON_RISE:   ton_rise_r <= cmd_i.data[15:0];
        PFSS_OFF_TOFF_DELAY: toff_delay_r <= cmd_i.data[15:0];
        PFSS_OFF_TOFF_FALL:  toff_fall_r <= cmd_i.data[15:0];
        default: ;
      endcase
    end
  end

  // Which fault kinds caused the last stop from regulation
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) fault_seen_r <= 3'h0;
    else if (any_fault) fault_seen_r <= {flt_s2_r[2], flt_s2_r[1], flt_s2_r[0]};
    else if (cmd_i.wr && cmd_i.addr == PFSS_OFF_CLEAR) fault_seen_r <= 3'h0;
  end

  // Sequencer: delays, ramps, fault stop, hiccup
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_r   <= PFSS_IDLE;
      tmr_r     <= '0;
      latched_r <= 1'b0;
    end else begin
      if (tmr_r != '0) tmr_r <= tmr_r - CW'(1);
      case (state_r)
        PFSS_IDLE: begin
          if (cmd_i.wr && cmd_i.addr == PFSS_OFF_CLEAR) latched_r <= 1'b0; // RULE3
          if (!enable) latched_r <= 1'b0; // RULE3
          if (enable && !latched_r) begin
            state_r <= PFSS_ON_WAIT;
            tmr_r   <= ms_to_cyc(ton_delay_r); // RULE20
          end
        end
        PFSS_ON_WAIT: begin
          if (!enable) state_r <= PFSS_IDLE;
          else if (tmr_r == '0) begin
            state_r <= PFSS_RISE;
            tmr_r   <= ms_to_cyc(ton_rise_r);
          end
        end
        PFSS_RISE: begin
          if (!enable) state_r <= PFSS_IDLE;
          else if (flt_s2_r[2]) state_r <= PFSS_FAULT;
          else if (tmr_r == '0) state_r <= PFSS_REG;
        end
        PFSS_REG: begin
          if (any_fault) begin
            state_r <= PFSS_FAULT;
            if ((flt_s2_r[2] && uv_resp_r == PFSS_RESP_HICCUP) ||
                (flt_s2_r[1] && oc_resp_r == PFSS_RESP_HICCUP) ||
                (flt_s2_r[0] && uc_resp_r == PFSS_RESP_HICCUP)) begin
              tmr_r <= CW'(HICCUP_CYCLES); // RULE26
            end else begin
              latched_r <= 1'b1; // RULE3
            end
          end else if (!enable) begin
            state_r <= PFSS_OFF_WAIT;
            tmr_r   <= ms_to_cyc(toff_delay_r); // RULE20
          end
        end
        PFSS_OFF_WAIT: begin
          if (tmr_r == '0) begin
            state_r <= soft_stop_r ? PFSS_FALL : PFSS_IDLE; // RULE21
            tmr_r   <= ms_to_cyc(toff_fall_r);
          end
        end
        PFSS_FALL: if (tmr_r == '0) state_r <= PFSS_IDLE; // RULE21
        PFSS_FAULT: begin
          if (latched_r) begin
            state_r <= PFSS_IDLE; // RULE3
          end else if (tmr_r == '0) begin
            // Restart attempts repeat while the fault persists
            state_r <= PFSS_IDLE; // RULE4
          end
        end
        default: state_r <= PFSS_IDLE;
      endcase
    end
  end

  // Sync event from link domain: three flops, edge on the last two
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) tick_sync_r <= 3'h0;
    else          tick_sync_r <= {tick_sync_r[1:0], link_tick};
  end

  pfss_sync_link u_link (
    .link_clk_i (link_clk_i),
    .rst_n_i    (rst_n_i),
    .in_div_i   (sync_setup_r[PFSS_SY_IN_DIV_L +: 6]), // RULE15
    .run_i      (use_ext_clk_o),
    .tick_o     (link_tick)
  );

  // Status and pin outputs, all registered
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      supply_ok_out_o <= 1'b0;
      regulate_o      <= 1'b0;
      uv_limit_o      <= '0;
      eff_freq_o      <= '0;
      use_ext_clk_o   <= 1'b0;
      sync_drive_o    <= 1'b0;
      sync_oe_o       <= 1'b0;
      ramp_dir_o      <= 2'h0;
      ms_left_r       <= '0;
    end else begin
      supply_ok_out_o <= (state_r == PFSS_REG) && !any_fault; // RULE6
      regulate_o      <= (state_r == PFSS_RISE) || (state_r == PFSS_REG) ||
                         (state_r == PFSS_OFF_WAIT) || (state_r == PFSS_FALL);
      uv_limit_o      <= vout_r - uv_off_r; // RULE1
      eff_freq_o      <= {freq_r, 1'b0}; // RULE10
      // External clock only if pin is sync-in and a channel selects it
      use_ext_clk_o   <= (pin_assign_r[PFSS_PIN_SYNC_MSB:PFSS_PIN_SYNC_LSB] == PFSS_PIN_SYNC_IN) &&
                         (sync_setup_r[PFSS_SY_SRC_A] | sync_setup_r[PFSS_SY_SRC_B]); // RULE14
      sync_oe_o       <= (pin_assign_r[PFSS_PIN_SYNC_MSB:PFSS_PIN_SYNC_LSB] == PFSS_PIN_SYNC_OUT) &&
                         sync_setup_r[PFSS_SY_OUT_EN]; // RULE13
      sync_drive_o    <= tick_sync_r[2] ^ tick_sync_r[1];
      ramp_dir_o      <= (state_r == PFSS_RISE) ? 2'h1 : (state_r == PFSS_FALL) ? 2'h2 : 2'h0;
      ms_left_r       <= tmr_r[15:0];
    end
  end

  // Register readback
  always_comb begin
    rd_data_o = '0;
    case (rd_addr_i)
      PFSS_OFF_PIN_ASSIGN: rd_data_o = PFSS_DATA_W'(pin_assign_r);
      PFSS_OFF_SYNC_SETUP: rd_data_o = PFSS_DATA_W'(sync_setup_r); // RULE16 RULE17 RULE19
      PFSS_OFF_ONOFF_CFG:  rd_data_o = PFSS_DATA_W'({pol_high_r, soft_stop_r}); // RULE21 RULE25
      PFSS_OFF_CMD_VOUT:   rd_data_o = PFSS_DATA_W'(vout_r);
      PFSS_OFF_UV_LIMIT:   rd_data_o = PFSS_DATA_W'(uv_limit_o);
      PFSS_OFF_UV_RESP:    rd_data_o = PFSS_DATA_W'(uv_resp_r);
      PFSS_OFF_OC_RESP:    rd_data_o = PFSS_DATA_W'(oc_resp_r);
      PFSS_OFF_UC_RESP:    rd_data_o = PFSS_DATA_W'(uc_resp_r);
      PFSS_OFF_FREQ:       rd_data_o = PFSS_DATA_W'(freq_r);
      PFSS_OFF_STATUS:     rd_data_o = PFSS_DATA_W'({latched_r, fault_seen_r, ms_left_r});
      default:             rd_data_o = '0;
    endcase
  end
endmodule : pfss_top

// ---- pfss_pkg.sv ----
// Package for the point-of-load fault and sync sequencer.
// Assumes one 10 MHz system clock; sizes follow the register map.
package pfss_pkg;

  // Register map
  localparam logic [7:0] PFSS_OFF_PIN_ASSIGN = 8'hcd;
  localparam logic [7:0] PFSS_OFF_SYNC_SETUP = 8'he4;
  localparam logic [7:0] PFSS_OFF_CMD_VOUT   = 8'h21;
  localparam logic [7:0] PFSS_OFF_UV_LIMIT   = 8'h44;
  localparam logic [7:0] PFSS_OFF_UV_RESP    = 8'h45;
  localparam logic [7:0] PFSS_OFF_OC_RESP    = 8'h47;
  localparam logic [7:0] PFSS_OFF_UC_RESP    = 8'h4c;
  localparam logic [7:0] PFSS_OFF_CLEAR      = 8'h03;
  localparam logic [7:0] PFSS_OFF_ONOFF_CFG  = 8'h02;
  localparam logic [7:0] PFSS_OFF_OPERATION  = 8'h01;
  localparam logic [7:0] PFSS_OFF_FREQ       = 8'h33;
  localparam logic [7:0] PFSS_OFF_TON_DELAY  = 8'h60;
  localparam logic [7:0] PFSS_OFF_TON_RISE   = 8'h61;
  localparam logic [7:0] PFSS_OFF_TOFF_DELAY = 8'h64;
  localparam logic [7:0] PFSS_OFF_TOFF_FALL  = 8'h65;
  localparam logic [7:0] PFSS_OFF_STATUS     = 8'h79;

  localparam int PFSS_PIN_W  = 150;
  localparam int PFSS_SYNC_W = 48;
  localparam int PFSS_DATA_W = 150;

  // Pin assignment field
  localparam int PFSS_PIN_SYNC_LSB = 120;
  localparam int PFSS_PIN_SYNC_MSB = 129;
  localparam logic [9:0] PFSS_PIN_SYNC_IN  = 10'h001;
  localparam logic [9:0] PFSS_PIN_SYNC_OUT = 10'h002;

  // Sync setup fields
  localparam int PFSS_SY_OUT_EN   = 47;
  localparam int PFSS_SY_IN_DIV_L = 41;
  localparam int PFSS_SY_PH_B_L   = 28;
  localparam int PFSS_SY_DIV_B_L  = 24;
  localparam int PFSS_SY_PH_A_L   = 20;
  localparam int PFSS_SY_DIV_A_L  = 16;
  localparam int PFSS_SY_GAIN_B_L = 38;
  localparam int PFSS_SY_GAIN_A_L = 14;
  localparam int PFSS_SY_LOCK_B   = 11;
  localparam int PFSS_SY_LOCK_A   = 8;
  localparam int PFSS_SY_OUT_SEL  = 7;
  localparam int PFSS_SY_SRC_B    = 6;
  localparam int PFSS_SY_SRC_A    = 5;

  // Voltage in 1 mV steps; default guard offset 0.192 V
  localparam logic [15:0] PFSS_UV_OFFSET_RST = 16'h00c0;
  localparam logic [15:0] PFSS_VOUT_RST      = 16'h03e8;
  // Frequency in kHz
  localparam logic [15:0] PFSS_FREQ_RST      = 16'h01f4;
  localparam logic [15:0] PFSS_FREQ_HIGH_V   = 16'h0320;
  // Timing in ms and cycles per ms at 10 MHz
  localparam int CLK_KHZ = 10000;
  localparam int PFSS_MS_CYCLES = CLK_KHZ;
  localparam logic [15:0] PFSS_TIME_RST = 16'h0005;
  localparam int PFSS_HICCUP_MS = 100;
  localparam int PFSS_HICCUP_CYCLES = PFSS_HICCUP_MS * PFSS_MS_CYCLES;

  localparam logic [1:0] PFSS_RESP_LATCH  = 2'h0;
  localparam logic [1:0] PFSS_RESP_HICCUP = 2'h1;

  typedef enum logic [2:0] {
    PFSS_IDLE, PFSS_ON_WAIT, PFSS_RISE, PFSS_REG, PFSS_OFF_WAIT, PFSS_FALL, PFSS_FAULT
  } pfss_state_type;

  typedef struct packed {
    logic        wr;
    logic [7:0]  addr;
    logic [PFSS_DATA_W-1:0] data;
  } pfss_cmd_type;

  typedef struct packed {
    logic uv;
    logic oc;
    logic uc;
  } pfss_fault_type;

endpackage : pfss_pkg

// ---- pfss_sync_link.sv ----
// Link-side logic running on the sync line's own clock.
// Assumes settings arrive quasi-static (changed only with output off).
`timescale 1ns/1ps
module pfss_sync_link (
  input  wire logic       link_clk_i,
  input  wire logic       rst_n_i,
  input  wire logic [5:0] in_div_i,
  input  wire logic       run_i,
  output logic            tick_o
);
  import pfss_pkg::*;

  logic [1:0] run_sync_r;
  logic [5:0] cnt_r;

  // Synchronise the enable into the link domain
  always_ff @(posedge link_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) run_sync_r <= 2'h0;
    else          run_sync_r <= {run_sync_r[0], run_i};
  end

  // Divide the incoming sync clock, toggle an event per period
  always_ff @(posedge link_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_r  <= 6'h00;
      tick_o <= 1'b0;
    end else if (run_sync_r[1]) begin
      if (cnt_r >= in_div_i) begin
        cnt_r  <= 6'h00;
        tick_o <= ~tick_o;
      end else begin
        cnt_r <= cnt_r + 6'h01;
      end
    end
  end
endmodule : pfss_sync_link

// ---- pfss_asserts.sv ----
// Checker on the sequencer top ports, bound below.
// Assumes the top drives registered outputs on clk_i.
`timescale 1ns/1ps
module pfss_asserts (
  input wire logic              clk_i,
  input wire logic              rst_n_i,
  input pfss_pkg::pfss_cmd_type   cmd_i,
  input wire logic [7:0]        rd_addr_i,
  input wire logic [149:0]      rd_data_o,
  input pfss_pkg::pfss_fault_type fault_i,
  input wire logic              supply_ok_out_o,
  input wire logic              regulate_o,
  input wire logic [16:0]       eff_freq_o,
  input wire logic              use_ext_clk_o,
  input wire logic [1:0]        ramp_dir_o
);
  import pfss_pkg::*;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // Ramp finished cleanly with no fault pin raised
  sequence s_ramp_done;
    ramp_dir_o == 2'h1 ##1 (ramp_dir_o == 2'h0 && regulate_o && fault_i == '0);
  endsequence
  // Frequency readback selected, no write for three cycles
  sequence s_freq_quiet;
    (rd_addr_i == PFSS_OFF_FREQ && !cmd_i.wr) [*3];
  endsequence
  AST_PG_NEEDS_REG: assert property (supply_ok_out_o |-> regulate_o && ramp_dir_o != 2'h1)
    else $error("power good while not regulating");
  AST_PG_AFTER_RAMP: assert property (s_ramp_done |-> ##[0:2] supply_ok_out_o)
    else $error("power good missing after ramp");
  AST_RISE_IGNORES_OC: assert property (ramp_dir_o == 2'h1 && !fault_i.uv && !fault_i.uc |=> regulate_o)
    else $error("ramp aborted by current fault");
  AST_CUR_FAULT_DROPS_PG: assert property ((fault_i.oc || fault_i.uc) && supply_ok_out_o |-> ##[1:5] !supply_ok_out_o)
    else $error("current fault left power good high");
  AST_UV_STOPS: assert property (fault_i.uv && supply_ok_out_o |-> ##[1:5] !regulate_o)
    else $error("undervoltage did not stop output");
  AST_FREQ_DOUBLE: assert property (s_freq_quiet |-> eff_freq_o == {rd_data_o[15:0], 1'b0})
    else $error("effective rate not twice per-phase");
  AST_EXT_CLK_CAUSE: assert property ($rose(use_ext_clk_o) |-> $past(cmd_i.wr) || $past(cmd_i.wr, 2))
    else $error("external clock chosen without a write");
  AST_SYNC_REFUSED: assert property (cmd_i.wr && cmd_i.addr == PFSS_OFF_SYNC_SETUP && supply_ok_out_o
    |=> $stable(use_ext_clk_o) [*3])
    else $error("sync setup changed while regulating");
endmodule : pfss_asserts

bind pfss_top pfss_asserts u_asserts (.clk_i(clk_i), .rst_n_i(rst_n_i), .cmd_i(cmd_i), .rd_addr_i(rd_addr_i),
  .rd_data_o(rd_data_o), .fault_i(fault_i), .supply_ok_out_o(supply_ok_out_o), .regulate_o(regulate_o),
  .eff_freq_o(eff_freq_o), .use_ext_clk_o(use_ext_clk_o), .ramp_dir_o(ramp_dir_o));

// ---- pfss_host_model.sv ----
// Host partner: issues command writes on the system clock.
// Assumes the caller orders pin assignment and sync setup.
`timescale 1ns/1ps
module pfss_host_model (
  input  wire logic           clk_i,
  output pfss_pkg::pfss_cmd_type cmd_o
);
  import pfss_pkg::*;
  initial cmd_o = '0;
  // One-cycle strobe; fields scrambled once released
  task automatic wr(input logic [7:0] a, input logic [PFSS_DATA_W-1:0] d);
    @(posedge clk_i);
    cmd_o <= '{wr: 1'b1, addr: a, data: d};
    @(posedge clk_i);
    cmd_o <= '{wr: 1'b0, addr: ~a, data: ~d};
  endtask : wr
endmodule : pfss_host_model

// ---- pfss_tb_top.sv ----
// Self-checking bench for the fault and sync sequencer.
// Assumes MS_CYCLES 4 and HICCUP_CYCLES 20 on the top.
`timescale 1ns/1ps
module pfss_tb_top;
  import pfss_pkg::*;
  localparam int MSC = 4;
  localparam int HIC = 20;
  typedef struct packed {logic [7:0] a; logic [15:0] d; logic [15:0] uv; logic [16:0] fq;} pfss_row_type;
  logic           clk_i = 1'b0, link_clk_i = 1'b0, rst_n_i = 1'b0, remote_on_i = 1'b0;
  logic [7:0]     rd_addr_i = 8'h00;
  pfss_fault_type fault_i = '0;
  pfss_cmd_type   cmd;
  logic [149:0]   rd_data, rv;
  logic           pg, reg_on, ext, sdrv, soe;
  logic [15:0]    uvl;
  logic [16:0]    frq;
  logic [1:0]     rdir;
  int             fail_count = 0, num_checks = 0, n;
  longint         t0;
  logic [7:0]     rsp [3] = '{PFSS_OFF_UV_RESP, PFSS_OFF_OC_RESP, PFSS_OFF_UC_RESP};
  pfss_row_type   rows [5] = '{'{PFSS_OFF_CMD_VOUT, 16'h0708, 16'h0648, 17'h003e8},
    '{PFSS_OFF_FREQ, 16'h0320, 16'h0648, 17'h00640}, '{PFSS_OFF_UV_LIMIT, 16'h05dc, 16'h05dc, 17'h00640},
    '{PFSS_OFF_CMD_VOUT, 16'h0ce4, 16'h0bb8, 17'h00640}, '{PFSS_OFF_FREQ, 16'h01f4, 16'h0bb8, 17'h003e8}};
  // Clocks; link edges never meet system edges
  always #50 clk_i = ~clk_i;
  initial begin
    #37;
    forever #80 link_clk_i = ~link_clk_i;
  end
  pfss_host_model host (.clk_i(clk_i), .cmd_o(cmd));
  pfss_top #(.HICCUP_CYCLES(HIC), .MS_CYCLES(MSC)) DUT (.clk_i(clk_i), .rst_n_i(rst_n_i), .link_clk_i(link_clk_i),
    .cmd_i(cmd), .rd_addr_i(rd_addr_i), .rd_data_o(rd_data), .remote_on_i(remote_on_i), .fault_i(fault_i),
    .supply_ok_out_o(pg), .regulate_o(reg_on), .uv_limit_o(uvl), .eff_freq_o(frq), .use_ext_clk_o(ext),
    .sync_drive_o(sdrv), .sync_oe_o(soe), .ramp_dir_o(rdir));
  task automatic chk_val(input logic [149:0] got, input logic [149:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %0t got %0h want %0h", $time, got, exp);
    end
  endtask : chk_val
  task automatic cyc(input int k);
    repeat (k) @(posedge clk_i);
  endtask : cyc
  task automatic rd(input logic [7:0] a);
    @(posedge clk_i);
    rd_addr_i <= a;
    @(posedge clk_i);
    #1 rv = rd_data;
  endtask : rd
  function automatic logic pick(input int s);
    return (s == 0) ? pg : (s == 1) ? reg_on : (s == 2) ? rdir[1] : sdrv;
  endfunction : pick
  // Bounded wait for a level, then compare it
  task automatic wait_sig(input int s, input logic v, input int lim);
    n = 0;
    do begin
      @(posedge clk_i);
      #1 n++;
    end while (pick(s) !== v && n < lim);
    chk_val(pick(s), v);
  endtask : wait_sig
  task automatic stop_test;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : stop_test
  // Watchdog well beyond the at most 652 cycles the whole test can take
  initial begin
    #(4000 * 100);
    fail_count++;
    stop_test();
  end
  initial begin
    cyc(16);
    rst_n_i <= 1'b1;
    cyc(3);
    #1 chk_val(uvl, 16'd808);
    chk_val({frq, ext, soe}, {17'd1000, 2'b00});
    foreach (rsp[i]) begin
      rd(rsp[i]); chk_val(rv[0], 1'b0);
    end
    rd(PFSS_OFF_ONOFF_CFG); chk_val(rv[0], 1'b0);
    foreach (rows[i]) begin
      host.wr(rows[i].a, 150'(rows[i].d));
      rd(rows[i].a);
      cyc(3);
      #1 chk_val(uvl, rows[i].uv);
      chk_val(frq, rows[i].fq);
    end
    // Sync source, then sync follower
    host.wr(PFSS_OFF_PIN_ASSIGN, 150'(PFSS_PIN_SYNC_OUT) << PFSS_PIN_SYNC_LSB);
    host.wr(PFSS_OFF_SYNC_SETUP, 150'h800001010100);
    rd(PFSS_OFF_SYNC_SETUP); chk_val(rv[47:0], 48'h800001010100);
    cyc(2);
    #1 chk_val(soe, 1'b1);
    host.wr(PFSS_OFF_PIN_ASSIGN, 150'(PFSS_PIN_SYNC_IN) << PFSS_PIN_SYNC_LSB);
    host.wr(PFSS_OFF_SYNC_SETUP, 150'h000030304160);
    rd(PFSS_OFF_SYNC_SETUP); chk_val(rv[47:0], 48'h000030304160);
    cyc(2);
    #1 chk_val({ext, soe}, 2'b10);
    wait_sig(3, 1'b1, 20);
    // Start-up with a current fault during the ramp
    host.wr(PFSS_OFF_TON_DELAY, 150'd2);
    host.wr(PFSS_OFF_TON_RISE, 150'd3);
    @(posedge clk_i) remote_on_i <= 1'b1;
    t0 = $time;
    cyc(9);
    #1 chk_val(reg_on, 1'b0);
    wait_sig(1, 1'b1, 20);
    @(posedge clk_i) fault_i.oc <= 1'b1;
    cyc(4);
    fault_i.oc <= 1'b0;
    wait_sig(0, 1'b1, 40);
    chk_val(($time - t0) inside {[2000:2900]}, 1'b1);
    host.wr(PFSS_OFF_SYNC_SETUP, 150'h0);
    rd(PFSS_OFF_SYNC_SETUP); chk_val(rv[47:0], 48'h000030304160);
    // Undervoltage latches off until cleared
    @(posedge clk_i) fault_i.uv <= 1'b1;
    wait_sig(1, 1'b0, 8);
    @(posedge clk_i) fault_i.uv <= 1'b0;
    cyc(40);
    #1 chk_val({reg_on, pg}, 2'b00);
    host.wr(PFSS_OFF_CLEAR, 150'h0);
    wait_sig(0, 1'b1, 80);
    // Reverse current in hiccup mode
    host.wr(PFSS_OFF_UC_RESP, 150'h1);
    @(posedge clk_i) fault_i.uc <= 1'b1;
    wait_sig(1, 1'b0, 8);
    wait_sig(1, 1'b1, 60);
    chk_val(n >= HIC - 2, 1'b1);
    wait_sig(1, 1'b0, 40);
    @(posedge clk_i) fault_i.uc <= 1'b0;
    wait_sig(0, 1'b1, 90);
    // Soft stop with off-delay and fall time
    host.wr(PFSS_OFF_ONOFF_CFG, 150'h3);
    host.wr(PFSS_OFF_TOFF_DELAY, 150'd1);
    host.wr(PFSS_OFF_TOFF_FALL, 150'd2);
    @(posedge clk_i) remote_on_i <= 1'b0;
    cyc(5);
    #1 chk_val(reg_on, 1'b1);
    wait_sig(2, 1'b1, 10);
    wait_sig(1, 1'b0, 20);
    // Active-low enable, then immediate stop
    host.wr(PFSS_OFF_ONOFF_CFG, 150'h0);
    wait_sig(0, 1'b1, 80);
    @(posedge clk_i) remote_on_i <= 1'b1;
    wait_sig(1, 1'b0, 12);
    chk_val(rdir, 2'b00);
    stop_test();
  end
endmodule : pfss_tb_top
